// ---- inc/cpu_space_pkg.sv ----
// constants and types for the address space, register file and stack block
package cpu_space_pkg;
    localparam int PROG_ADDR_W = 13;
    localparam int REG_ADDR_W = 8;
    localparam int PROG_BYTES = 8192;
    localparam logic [12:0] VECTOR_LO_ADDR = 13'h0000;
    localparam logic [12:0] VECTOR_HI_ADDR = 13'h0001;
    localparam logic [12:0] OPTION_FIRST_ADDR = 13'h003c;
    localparam logic [12:0] OPTION_LAST_ADDR = 13'h003f;
    localparam logic [7:0] OPTION_BLANK = 8'hff;
    localparam logic [12:0] RESET_FETCH_ADDR = 13'h0100;
    localparam logic [7:0] GP_LAST_ADDR = 8'hbf;
    localparam logic [7:0] COMMON_FIRST_ADDR = 8'hc0;
    localparam logic [7:0] COMMON_LAST_ADDR = 8'hcf;
    localparam logic [7:0] SYS_FIRST_ADDR = 8'hd0;
    localparam logic [7:0] STACK_POINTER_ADDR = 8'hd9;
    localparam logic [7:0] FLAGS_ADDR = 8'hd5;
    localparam logic [7:0] STACK_POINTER_RESET = 8'h00;
    localparam logic [7:0] SP_RECOMMENDED = 8'hc0;
    localparam int SYS_REG_COUNT = 45;
    localparam int GP_REG_COUNT = 208;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_CALL,
        OP_RETURN,
        OP_INT_ENTRY,
        OP_INT_RETURN
    } stack_op_e;

    typedef enum logic [1:0] {
        MODE_REGISTER,
        MODE_WORKING,
        MODE_INDIRECT
    } addr_mode_e;

    // register file region of an address
    typedef enum logic [1:0] {
        REGION_GENERAL,
        REGION_COMMON,
        REGION_SYSTEM
    } region_e;

    function automatic region_e region_of(input logic [7:0] a);
        if (a <= GP_LAST_ADDR)
            return REGION_GENERAL;
        else if (a <= COMMON_LAST_ADDR)
            return REGION_COMMON;
        else
            return REGION_SYSTEM;
    endfunction

    // even register of a pair
    function automatic logic [7:0] pair_base(input logic [7:0] a);
        return {a[7:1], 1'b0};
    endfunction
endpackage

// ---- rtl/code_store.sv ----
// program memory with vector, option cells and reset fetch area
`timescale 1ns/100ps
module code_store
    import cpu_space_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic clkEn,
    // fetch and table read
    input wire logic [12:0] progAddr,
    output logic [7:0] progData,
    output logic isOptionCell,
    output logic isVector,
    // programming port
    input wire logic progWrEn,
    input wire logic [12:0] progWrAddr,
    input wire logic [7:0] progWrData
);
    logic [7:0] mem [PROG_BYTES];
    logic [7:0] rd_q;

    initial
    begin
        for (int i = 0; i < PROG_BYTES; i++)
            mem[i] = OPTION_BLANK;
    end

    // plain always: the blank fill above also writes this array
    always @(posedge clk)
    begin
        if (clkEn && progWrEn)
            mem[progWrAddr] <= progWrData;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            rd_q <= 8'h00;
        else if (clkEn)
            rd_q <= mem[progAddr];
    end

    assign progData = rd_q;
    assign isOptionCell = progAddr >= OPTION_FIRST_ADDR &&
        progAddr <= OPTION_LAST_ADDR;
    assign isVector = progAddr <= VECTOR_HI_ADDR;
endmodule

// ---- rtl/cpu_address_space_and_stack.sv ----
// address spaces, register file decode and system stack of the core
`timescale 1ns/100ps
// Functional notes
// - 13-bit program address bus; separate 8-bit register bus
// - 8 Kbytes of program memory, all usable in internal mode
// - bytes 0000h-0001h are interrupt vector; rest to 00ffh ordinary
// - 003ch-003fh are option cells; blank cell reads ffh
// - after reset fetch starts at 0100h
// - c0h-ffh hold working, system and peripheral registers
// - 00h-bfh general purpose, no banked pages
// - 45 system bytes and 208 general purpose bytes
// - c0h-cfh common working area reachable from any page
// - pair starts even; high byte even, low byte odd
// - call pushes program counter; return pops it
// - interrupt pushes counter and flags; interrupt return pops both
// - pointer decrements before push, increments after pop
// - stack pointer holds address of most recent pushed entry
// - 8-bit stack pointer at d9h, reset value undefined; reset here loads 00h
// - pointer wraps modulo 256; software should start at c0h
// - register mode operand is the named register or pair
// - working mode: pointer picks 8-byte block, field picks register
// - indirect: 8-bit register addresses file, pair addresses memory
module cpu_address_space_and_stack
    import cpu_space_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic clkEn,
    // register bus from the core
    input wire logic regWrEn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    output logic regIsSystem,
    // operand address formation
    input wire addr_mode_e opMode,
    input wire logic [7:0] opField,
    input wire logic [7:0] workPointer,
    input wire logic opPair,
    output logic [7:0] opRegAddr,
    output logic [15:0] opValue,
    output logic [15:0] opMemAddr,
    // fetch and program counter
    input wire logic pcLoad,
    input wire logic [12:0] pcLoadValue,
    input wire logic pcStep,
    input wire logic [12:0] tableAddr,
    input wire logic tableSel,
    output logic [12:0] programCounter,
    output logic [7:0] progData,
    output logic progIsOption,
    output logic progIsVector,
    // code store programming
    input wire logic progWrEn,
    input wire logic [12:0] progWrAddr,
    input wire logic [7:0] progWrData,
    // stack sequencing
    input wire stack_op_e stackOp,
    input wire logic [7:0] flagsIn,
    output logic stackBusy,
    output logic flagsRestore,
    output logic [7:0] flagsOut,
    output logic [7:0] stackPointer
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PUSH_LO,
        ST_PUSH_HI,
        ST_PUSH_FLAGS,
        ST_POP_FLAGS,
        ST_POP_HI,
        ST_POP_LO
    } stack_state_e;

    typedef struct packed {
        logic [12:0] pc;
        logic [7:0] sp;
        stack_state_e st;
        logic withFlags;
        logic [7:0] flags;
        logic flagsRestore;
        logic [7:0] popHi;
    } state_s;

    state_s s_q;
    state_s s_d;
    logic stkWr;
    logic [7:0] stkAddr;
    logic [7:0] stkData;
    logic arrWr;
    logic [7:0] arrWrAddr;
    logic [7:0] arrWrData;
    logic [7:0] rdA;
    logic [7:0] rdB;
    logic [7:0] addrA;
    logic [7:0] addrB;
    logic [7:0] stkRd;
    logic [12:0] progAddr;

    function automatic logic [7:0] sp_dec(input logic [7:0] v);
        return v - 8'h01;
    endfunction

    function automatic logic [7:0] sp_inc(input logic [7:0] v);
        return v + 8'h01;
    endfunction

    // operand address: register, working block or pointer register
    always_comb
    begin
        case (opMode)
            MODE_WORKING:
                opRegAddr = {workPointer[7:3], opField[2:0]};
            MODE_INDIRECT:
                opRegAddr = opField;
            MODE_REGISTER:
                opRegAddr = opField;
            default:
                opRegAddr = opField;
        endcase
        if (opPair)
            opRegAddr = pair_base(opRegAddr);
    end

    assign addrA = opRegAddr;
    assign addrB = {opRegAddr[7:1], 1'b1};

    // pair value: even register high byte; indirect target likewise
    always_comb
    begin
        if (opPair)
        begin
            opValue = {rdA, rdB};
            opMemAddr = {rdA, rdB};
        end
        else
        begin
            opValue = {8'h00, rdA};
            opMemAddr = {8'h00, rdA};
        end
    end

    // stack writes take the register array port; core writes otherwise
    assign arrWr = stkWr | (regWrEn && regAddr != STACK_POINTER_ADDR);
    assign arrWrAddr = stkWr ? stkAddr : regAddr;
    assign arrWrData = stkWr ? stkData : regWrData;

    // port c reads the odd half of an operand pair
    reg_array u_regs (
        .clk(clk),
        .clkEn(clkEn),
        .wrEn(arrWr),
        .wrAddr(arrWrAddr),
        .wrData(arrWrData),
        .rdAddrA(addrA),
        .rdDataA(rdA),
        .rdAddrB(s_q.st == ST_IDLE ? regAddr : s_q.sp),
        .rdDataB(stkRd),
        .rdAddrC(addrB),
        .rdDataC(rdB)
    );

    // register bus read decode
    always_comb
    begin
        case (region_of(regAddr))
            REGION_GENERAL:
                regRdData = stkRd;
            REGION_COMMON:
                regRdData = stkRd;
            REGION_SYSTEM:
            begin
                // only the stack pointer lives in system space here
                if (regAddr == STACK_POINTER_ADDR)
                    regRdData = s_q.sp;
                else
                    regRdData = 8'h00;
            end
            default:
                regRdData = 8'h00;
        endcase
    end
    assign regIsSystem = regAddr >= COMMON_FIRST_ADDR;

    assign progAddr = tableSel ? tableAddr : s_q.pc;

    code_store u_code (
        .clk(clk),
        .rst(rst),
        .clkEn(clkEn),
        .progAddr(progAddr),
        .progData(progData),
        .isOptionCell(progIsOption),
        .isVector(progIsVector),
        .progWrEn(progWrEn),
        .progWrAddr(progWrAddr),
        .progWrData(progWrData)
    );

    // stack sequencer: one byte per cycle
    always_comb
    begin
        s_d = s_q;
        s_d.flagsRestore = 1'b0;
        stkWr = 1'b0;
        stkAddr = s_q.sp;
        stkData = 8'h00;
        if (regWrEn && regAddr == STACK_POINTER_ADDR && s_q.st == ST_IDLE)
            s_d.sp = regWrData;
        if (pcStep)
            s_d.pc = s_q.pc + 13'h0001;
        case (s_q.st)
            ST_IDLE:
            begin
                // requests are taken only here; busy states ignore them
                if (stackOp == OP_CALL || stackOp == OP_INT_ENTRY)
                begin
                    s_d.st = ST_PUSH_LO;
                    s_d.withFlags = stackOp == OP_INT_ENTRY;
                    s_d.flags = flagsIn;
                end
                else if (stackOp == OP_INT_RETURN)
                    s_d.st = ST_POP_FLAGS;
                else if (stackOp == OP_RETURN)
                    s_d.st = ST_POP_HI;
                if (pcLoad)
                    s_d.pc = pcLoadValue;
            end
            ST_PUSH_LO:
            begin
                stkAddr = sp_dec(s_q.sp);
                stkData = s_q.pc[7:0];
                stkWr = 1'b1;
                s_d.sp = stkAddr;
                s_d.st = ST_PUSH_HI;
            end
            ST_PUSH_HI:
            begin
                stkAddr = sp_dec(s_q.sp);
                // five address bits; upper bits of the byte stay zero
                stkData = {3'b000, s_q.pc[12:8]};
                stkWr = 1'b1;
                s_d.sp = stkAddr;
                s_d.st = s_q.withFlags ? ST_PUSH_FLAGS : ST_IDLE;
                if (!s_q.withFlags)
                    s_d.pc = pcLoadValue;
            end
            ST_PUSH_FLAGS:
            begin
                stkAddr = sp_dec(s_q.sp);
                stkData = s_q.flags;
                stkWr = 1'b1;
                s_d.sp = stkAddr;
                s_d.pc = pcLoadValue;
                s_d.st = ST_IDLE;
            end
            ST_POP_FLAGS:
            begin
                s_d.flags = stkRd;
                s_d.flagsRestore = 1'b1;
                s_d.sp = sp_inc(s_q.sp);
                s_d.st = ST_POP_HI;
            end
            ST_POP_HI:
            begin
                s_d.popHi = stkRd;
                s_d.sp = sp_inc(s_q.sp);
                s_d.st = ST_POP_LO;
            end
            ST_POP_LO:
            begin
                // high byte carries only five address bits
                s_d.pc = {s_q.popHi[4:0], stkRd};
                s_d.sp = sp_inc(s_q.sp);
                s_d.st = ST_IDLE;
            end
            default:
                s_d.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_q.pc <= RESET_FETCH_ADDR;
            s_q.sp <= STACK_POINTER_RESET;
            s_q.st <= ST_IDLE;
            s_q.withFlags <= 1'b0;
            s_q.flags <= 8'h00;
            s_q.flagsRestore <= 1'b0;
            s_q.popHi <= 8'h00;
        end
        else if (clkEn)
            s_q <= s_d;
    end

    assign programCounter = s_q.pc;
    assign stackPointer = s_q.sp;
    assign stackBusy = s_q.st != ST_IDLE;
    assign flagsRestore = s_q.flagsRestore;
    assign flagsOut = s_q.flags;
endmodule

// ---- rtl/reg_array.sv ----
// register file storage, general purpose plus common working area
`timescale 1ns/100ps
module reg_array
    import cpu_space_pkg::*;
(
    // clock
    input wire logic clk,
    input wire logic clkEn,
    // write port
    input wire logic wrEn,
    input wire logic [7:0] wrAddr,
    input wire logic [7:0] wrData,
    // read ports
    input wire logic [7:0] rdAddrA,
    output logic [7:0] rdDataA,
    input wire logic [7:0] rdAddrB,
    output logic [7:0] rdDataB,
    input wire logic [7:0] rdAddrC,
    output logic [7:0] rdDataC
);
    // c0h-cfh common area follows 00h-bfh; system space not stored here
    logic [7:0] mem [GP_REG_COUNT];

    function automatic logic [7:0] idx(input logic [7:0] a);
        return a; // general and common areas are contiguous, 00h-cfh
    endfunction

    always_ff @(posedge clk)
    begin
        if (clkEn && wrEn && wrAddr <= COMMON_LAST_ADDR)
            mem[idx(wrAddr)] <= wrData;
    end

    assign rdDataA = (rdAddrA <= COMMON_LAST_ADDR) ?
        mem[idx(rdAddrA)] : 8'h00;
    assign rdDataB = (rdAddrB <= COMMON_LAST_ADDR) ?
        mem[idx(rdAddrB)] : 8'h00;
    assign rdDataC = (rdAddrC <= COMMON_LAST_ADDR) ?
        mem[idx(rdAddrC)] : 8'h00;
endmodule

// ---- verification/core_model.sv ----
// behavioural core issuing stack requests
`timescale 1ns/100ps
module core_model
    import cpu_space_pkg::*;
(
    // clock and handshake
    input wire logic clk,
    input wire logic stackBusy,
    // request lines
    output stack_op_e stackOp,
    output logic [7:0] flagsIn,
    output logic [12:0] pcLoadValue
);
    initial
    begin
        stackOp = OP_NONE;
        flagsIn = 8'h00;
        pcLoadValue = 13'h0000;
    end
    // idles gap cycles, requests, then waits out the sequence
    task automatic run(stack_op_e op, logic [7:0] f, logic [12:0] t,
        int gap);
        repeat (gap + 1) @(posedge clk);
        stackOp <= op;
        flagsIn <= f;
        pcLoadValue <= t;
        @(posedge clk);
        stackOp <= OP_NONE;
        flagsIn <= ~f;
        @(negedge clk);
        for (int n = 0; n < 12 && stackBusy; n++)
            @(negedge clk);
    endtask
endmodule

// ---- verification/cpu_address_space_and_stack_test.sv ----
// bench for the address space, register file and stack block
`timescale 1ns/100ps
module cpu_address_space_and_stack_test
    import cpu_space_pkg::*;
;
    logic clk = '0, rst = '1, clkEn = '1, regWrEn = '0, opPair = '0;
    logic pcLoad = '0, pcStep = '0, tableSel = '0, progWrEn = '0;
    logic regIsSystem, progIsOption, progIsVector, stackBusy, flagsRestore;
    logic [7:0] regAddr = '0, regWrData = '0, opField = '0, progWrData = '0;
    logic [7:0] workPointer = '0, regRdData, opRegAddr, progData, flagsIn;
    logic [7:0] flagsOut, stackPointer;
    logic [12:0] tableAddr = '0, progWrAddr = '0, pcLoadValue, programCounter;
    logic [15:0] opValue, opMemAddr;
    addr_mode_e opMode = MODE_REGISTER;
    stack_op_e stackOp;
    typedef struct {int s; logic [15:0] e;} note_s;
    note_s q[$];
    note_s cur;
    event look;
    int fail_count = 0;
    int n_compared = 0;
    logic [15:0] obs [9];
    string nm[9] = '{"pc", "sp", "rdata", "value", "pdata", "flag",
        "flags", "oaddr", "maddr"};

    cpu_address_space_and_stack cpu_address_space_and_stack_i (.*);
    core_model core_model_i (.*);
    always #25 clk = ~clk;
    assign obs = '{{3'h0, programCounter}, {8'h00, stackPointer},
        {8'h00, regRdData}, opValue, {8'h00, progData},
        {13'h0000, regIsSystem, progIsOption, progIsVector},
        {8'h00, flagsOut}, {8'h00, opRegAddr}, opMemAddr};

    task automatic check(string n, logic [15:0] s, logic [15:0] e);
        n_compared++;
        if (s !== e)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    // all queued notes are compared, oldest first, once the outputs settle
    initial forever
    begin
        @(look);
        #1;
        while (q.size() > 0)
        begin
            cur = q.pop_front();
            check(nm[cur.s], obs[cur.s], cur.e);
        end
    end
    task automatic note(int s, logic [15:0] e);
        q.push_back('{s, e});
        -> look;
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge clk);
        regWrEn <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        @(posedge clk);
        regAddr <= a;
        @(negedge clk);
        note(2, {8'h00, e});
    endtask
    task finish_test;
        if (fail_count == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        #500000;
        fail_count++;
        finish_test;
    end
    initial
    begin
        logic [7:0] a;
        logic [7:0] d;
        logic [7:0] e;
        logic [12:0] t;
        void'($urandom(32'h3b997d81));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        note(0, 16'h0100);
        for (int i = 0; i < 66; i++)
        begin
            @(posedge clk);
            tableSel <= 1'b1;
            tableAddr <= i[12:0];
            @(posedge clk);
            @(negedge clk);
            note(4, 16'h00ff);
            note(5, {14'h0000, i >= 60 && i <= 63, i < 2});
        end
        for (int i = 0; i < 24; i++)
        begin
            a = 8'($urandom);
            d = 8'($urandom);
            wr(a, d);
            @(negedge clk);
            note(5, {13'h0000, a >= COMMON_FIRST_ADDR, 2'b00});
            if (a <= COMMON_LAST_ADDR)
                rd(a, d);
        end
        d = 8'($urandom);
        e = 8'($urandom);
        wr(8'h20, d);
        wr(8'h21, e);
        @(posedge clk);
        opField <= 8'h21;
        opPair <= 1'b1;
        @(negedge clk);
        note(7, 16'h0020);
        note(3, {d, e});
        @(posedge clk);
        opMode <= MODE_INDIRECT;
        opField <= 8'h20;
        @(negedge clk);
        note(8, {d, e});
        @(posedge clk);
        opPair <= 1'b0;
        @(negedge clk);
        note(8, {8'h00, d});
        note(3, {8'h00, d});
        @(posedge clk);
        opMode <= MODE_WORKING;
        opPair <= 1'b0;
        opField <= 8'h05;
        workPointer <= 8'h28;
        @(negedge clk);
        note(7, 16'h002d);
        wr(STACK_POINTER_ADDR, SP_RECOMMENDED);
        rd(STACK_POINTER_ADDR, SP_RECOMMENDED);
        t = 13'($urandom);
        core_model_i.run(OP_CALL, 8'h00, t, $urandom_range(2));
        note(1, 16'h00be);
        note(0, {3'h0, t});
        rd(8'hbf, 8'h00);
        rd(8'hbe, 8'h01);
        core_model_i.run(OP_RETURN, 8'h00, t, 0);
        note(0, 16'h0100);
        note(1, 16'h00c0);
        d = 8'($urandom);
        core_model_i.run(OP_INT_ENTRY, d, t, $urandom_range(2));
        rd(8'hbd, d);
        core_model_i.run(OP_INT_RETURN, 8'h00, t, 1);
        note(6, {8'h00, d});
        note(0, 16'h0100);
        note(1, 16'h00c0);
        wr(STACK_POINTER_ADDR, 8'h00);
        core_model_i.run(OP_CALL, 8'h00, 13'h1fff, 0);
        note(1, 16'h00fe);
        @(posedge clk);
        clkEn <= 1'b0;
        pcStep <= 1'b1;
        repeat (3) @(posedge clk);
        clkEn <= 1'b1;
        @(posedge clk);
        pcStep <= 1'b0;
        @(negedge clk);
        note(0, 16'h0000);
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        note(0, 16'h0100);
        #100;
        finish_test;
    end
endmodule

// ---- verification/cpu_space_props.sv ----
// assertions on stack, pointer and decode behaviour
`timescale 1ns/100ps
module cpu_space_props
    import cpu_space_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic clkEn,
    // register bus and operands
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regRdData,
    input wire logic regIsSystem,
    input wire addr_mode_e opMode,
    input wire logic opPair,
    input wire logic [7:0] opRegAddr,
    // fetch and stack
    input wire logic [12:0] programCounter,
    input wire stack_op_e stackOp,
    input wire logic stackBusy,
    input wire logic flagsRestore,
    input wire logic [7:0] stackPointer
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [7:0] spReq_q;
    stack_op_e opReq_q;
    // pointer and kind of the last accepted stack request
    always_ff @(posedge clk)
    begin
        if (clkEn && !stackBusy && stackOp != OP_NONE)
        begin
            spReq_q <= stackPointer;
            opReq_q <= stackOp;
        end
    end
    a_reset_fetch:
        assert property ($fell(rst) |-> programCounter == RESET_FETCH_ADDR)
        else $error("pc not at reset fetch address");
    a_region_decode:
        assert property (regIsSystem == (regAddr >= COMMON_FIRST_ADDR))
        else $error("region decode wrong");
    a_pair_even:
        assert property (opPair && opMode == MODE_REGISTER |-> !opRegAddr[0])
        else $error("pair address odd");
    a_call_push:
        assert property ($fell(stackBusy) && opReq_q == OP_CALL
            |-> stackPointer == spReq_q - 8'h02) else $error("call push");
    a_int_push:
        assert property ($fell(stackBusy) && opReq_q == OP_INT_ENTRY
            |-> stackPointer == spReq_q - 8'h03) else $error("entry push");
    a_return_pop:
        assert property ($fell(stackBusy) && opReq_q == OP_RETURN
            |-> stackPointer == spReq_q + 8'h02) else $error("return pop");
    a_flags_pulse:
        assert property (flagsRestore |-> opReq_q == OP_INT_RETURN
            ##1 !flagsRestore) else $error("flags restore pulse");
    a_sp_read:
        assert property (regAddr == STACK_POINTER_ADDR
            |-> regRdData == stackPointer) else $error("pointer readback");
    c_call: cover property ($fell(stackBusy) && opReq_q == OP_CALL);
    c_interrupt_return_op: cover property (flagsRestore);
    c_wrap: cover property (stackPointer == 8'hfe && !stackBusy);
endmodule
bind cpu_address_space_and_stack cpu_space_props cpu_space_props_i (
    .clk, .rst, .clkEn, .regAddr, .regRdData, .regIsSystem, .opMode,
    .opPair, .opRegAddr, .programCounter, .stackOp, .stackBusy,
    .flagsRestore, .stackPointer
);
